/* File: ripple_consts.svh */
`ifndef RIPPLE_CONSTS_SVH
`define RIPPLE_CONSTS_SVH

// number of counter stages and stage weights
`define STAGE_COUNT      4
`define WEIGHT_1         4'h1
`define WEIGHT_2         4'h2
`define WEIGHT_4         4'h4
`define WEIGHT_8         4'h8
// stand-by value of the counter after cancel (all off)
`define COUNT_RESET      4'h0
// wrap count of the pure binary counter
`define COUNT_WRAP       5'h10
// stand-by states of the gated switch control stages
`define EDGE_STAGE_RESET 1'b0
`define QUAL_STAGE_RESET 1'b1

`endif

/* File: ripple_pkg.sv */
package ripple_pkg;

  // state of one bistable stage
  typedef enum logic {
    STAGE_OFF = 1'b0,
    STAGE_ON  = 1'b1
  } stage_state_t;

  typedef logic [3:0] digit_t;

endpackage

/* File: bistable_stage.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ripple_consts.svh"

// one bistable stage with toggle, set, clear and a cancel stand-by value
module bistable_stage #(
  parameter logic STANDBY = 1'b0
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic cancel_i,
  input  wire logic toggle_i,
  input  wire logic set_i,
  input  wire logic clear_i,
  output logic      state_o,
  output logic      rise_o,
  output logic      fall_o
);

  ripple_pkg::stage_state_t state_reg;
  ripple_pkg::stage_state_t state_next;

  // next state: cancel first, then set/clear, then toggle
  always_comb begin
    state_next = state_reg;
    if (cancel_i) begin
      state_next = ripple_pkg::stage_state_t'(STANDBY);
    end else if (set_i && !clear_i) begin
      state_next = ripple_pkg::STAGE_ON;
    end else if (clear_i && !set_i) begin
      state_next = ripple_pkg::STAGE_OFF;
    end else if (toggle_i) begin
      state_next = ripple_pkg::stage_state_t'(~state_reg);
    end
  end

  // stage holds its value between pulses
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ripple_pkg::stage_state_t'(STANDBY);
    end else begin
      state_reg <= state_next;
    end
  end

  // combinational edges let a ripple settle in one cycle
  assign state_o = state_reg;
  assign rise_o  = (state_reg == ripple_pkg::STAGE_OFF) &&
                   (state_next == ripple_pkg::STAGE_ON);
  assign fall_o  = (state_reg == ripple_pkg::STAGE_ON) &&
                   (state_next == ripple_pkg::STAGE_OFF);

endmodule // bistable_stage

`default_nettype wire

/* File: binary_ripple_counter.sv */
// How it works
// - each stage holds its state until a later pulse flips it.
// - four stages weighted 1,2,4,8; digit is sum of on weights.
// - stage one toggles on every input impulse.
// - stage two toggles when stage one goes on to off.
// - stage three toggles when stage two goes on to off.
// - stage four toggles when stage three goes on to off.
// - counter returns to zero after sixteen pulses, or on cancel.
// - gated switch pulses when edge stage turns on and qualifier is on.
// - gated switch output lasts one cycle per qualifying transition.
// - after cancel, qualifier stage is on and edge stage is off.
// - level drivers give complementary lines following a stage.
// - pulse former emits one pulse on each off-to-on transition.
// - cancel forces every stage to its stand-by state.
// - separate set and clear inputs; matching pulse has no effect.
`timescale 1ns/10ps
`default_nettype none
`include "ripple_consts.svh"

module binary_ripple_counter (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       cancel_i,
  input  wire logic       impulse_i,
  input  wire logic       edge_set_i,
  input  wire logic       edge_clear_i,
  input  wire logic       qual_set_i,
  input  wire logic       qual_clear_i,
  output logic [3:0]      digit_o,
  output logic            wrap_o,
  output logic [3:0]      on_pulse_o,
  output logic            on_level_line_o,
  output logic            off_level_line_o,
  output logic            on_state_driver_o,
  output logic            off_state_driver_o,
  output logic            gate_pulse_o,
  output logic            edge_stage_o,
  output logic            qual_stage_o
);

  // synchronised control lines
  logic [1:0] cancel_sync_reg;
  logic [1:0] impulse_sync_reg;
  logic [1:0] eset_sync_reg;
  logic [1:0] eclr_sync_reg;
  logic [1:0] qset_sync_reg;
  logic [1:0] qclr_sync_reg;
  logic       impulse_prev_reg;
  logic       eset_prev_reg;
  logic       eclr_prev_reg;
  logic       qset_prev_reg;
  logic       qclr_prev_reg;
  logic       cancel_s;
  logic       impulse_s;
  logic       eset_s;
  logic       eclr_s;
  logic       qset_s;
  logic       qclr_s;

  logic [3:0] stage_q;
  logic [3:0] stage_rise;
  logic [3:0] stage_fall;
  logic [3:0] stage_tog;
  logic       edge_q;
  logic       edge_rise;
  logic       qual_q;

  // two-flop synchronisers: pins come from another domain
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cancel_sync_reg  <= 2'h0;
      impulse_sync_reg <= 2'h0;
      eset_sync_reg    <= 2'h0;
      eclr_sync_reg    <= 2'h0;
      qset_sync_reg    <= 2'h0;
      qclr_sync_reg    <= 2'h0;
    end else begin
      cancel_sync_reg  <= {cancel_sync_reg[0], cancel_i};
      impulse_sync_reg <= {impulse_sync_reg[0], impulse_i};
      eset_sync_reg    <= {eset_sync_reg[0], edge_set_i};
      eclr_sync_reg    <= {eclr_sync_reg[0], edge_clear_i};
      qset_sync_reg    <= {qset_sync_reg[0], qual_set_i};
      qclr_sync_reg    <= {qclr_sync_reg[0], qual_clear_i};
    end
  end

  // previous levels for strobe forming
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      impulse_prev_reg <= 1'b0;
      eset_prev_reg    <= 1'b0;
      eclr_prev_reg    <= 1'b0;
      qset_prev_reg    <= 1'b0;
      qclr_prev_reg    <= 1'b0;
    end else begin
      impulse_prev_reg <= impulse_sync_reg[1];
      eset_prev_reg    <= eset_sync_reg[1];
      eclr_prev_reg    <= eclr_sync_reg[1];
      qset_prev_reg    <= qset_sync_reg[1];
      qclr_prev_reg    <= qclr_sync_reg[1];
    end
  end

  // a held input counts once: rising edge becomes a one-cycle strobe
  assign impulse_s = impulse_sync_reg[1] & ~impulse_prev_reg;
  assign eset_s    = eset_sync_reg[1] & ~eset_prev_reg;
  assign eclr_s    = eclr_sync_reg[1] & ~eclr_prev_reg;
  assign qset_s    = qset_sync_reg[1] & ~qset_prev_reg;
  assign qclr_s    = qclr_sync_reg[1] & ~qclr_prev_reg;
  assign cancel_s  = cancel_sync_reg[1]; // level: holds stand-by

  // ripple chain: each stage toggles when the one below falls
  assign stage_tog[0] = impulse_s;
  assign stage_tog[1] = stage_fall[0];
  assign stage_tog[2] = stage_fall[1];
  assign stage_tog[3] = stage_fall[2];

  genvar gi;
  generate
    for (gi = 0; gi < `STAGE_COUNT; gi = gi + 1) begin : g_stage
      bistable_stage #(
        .STANDBY (1'b0)
      ) u_stage (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .cancel_i  (cancel_s),
        .toggle_i  (stage_tog[gi]),
        .set_i     (1'b0),
        .clear_i   (1'b0),
        .state_o   (stage_q[gi]),
        .rise_o    (stage_rise[gi]),
        .fall_o    (stage_fall[gi])
      );
    end
  endgenerate

  // edge-providing control stage, rests off
  bistable_stage #(
    .STANDBY (`EDGE_STAGE_RESET)
  ) u_edge_stage (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .cancel_i  (cancel_s),
    .toggle_i  (1'b0),
    .set_i     (eset_s),
    .clear_i   (eclr_s),
    .state_o   (edge_q),
    .rise_o    (edge_rise),
    .fall_o    ()
  );

  // qualifying control stage, rests on
  bistable_stage #(
    .STANDBY (`QUAL_STAGE_RESET)
  ) u_qual_stage (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .cancel_i  (cancel_s),
    .toggle_i  (1'b0),
    .set_i     (qset_s),
    .clear_i   (qclr_s),
    .state_o   (qual_q),
    .rise_o    (),
    .fall_o    ()
  );

  // weighted sum of on stages
  function automatic ripple_pkg::digit_t weigh(input logic [3:0] s);
    weigh = (s[0] ? `WEIGHT_1 : 4'h0) | (s[1] ? `WEIGHT_2 : 4'h0) |
            (s[2] ? `WEIGHT_4 : 4'h0) | (s[3] ? `WEIGHT_8 : 4'h0);
  endfunction

  // registered digit view, one cycle after the stage flops
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      digit_o <= `COUNT_RESET;
    end else begin
      digit_o <= weigh(stage_q);
    end
  end

  // wrap marks the sixteenth pulse: top stage falling to all off
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wrap_o <= 1'b0;
    end else begin
      wrap_o <= stage_fall[3] & ~cancel_s;
    end
  end

  // pulse formers: one cycle per off-to-on change of each stage
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_pulse_o <= 4'h0;
    end else begin
      on_pulse_o <= stage_rise;
    end
  end

  // level drivers following stage one; complementary by design
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_level_line_o    <= 1'b0;
      off_level_line_o   <= 1'b1;
      on_state_driver_o  <= 1'b0;
      off_state_driver_o <= 1'b1;
    end else begin
      on_level_line_o    <= stage_q[0];
      off_level_line_o   <= ~stage_q[0];
      on_state_driver_o  <= stage_q[0];
      off_state_driver_o <= ~stage_q[0];
    end
  end

  // gated switch: edge coupled on edge stage, level on qualifier
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_pulse_o <= 1'b0;
    end else begin
      gate_pulse_o <= edge_rise & qual_q;
    end
  end

  // control stage views
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edge_stage_o <= `EDGE_STAGE_RESET;
      qual_stage_o <= `QUAL_STAGE_RESET;
    end else begin
      edge_stage_o <= edge_q;
      qual_stage_o <= qual_q;
    end
  end

endmodule // binary_ripple_counter

`default_nettype wire

/* File: impulse_source.sv */
`timescale 1ns/10ps
`default_nettype none
// far-side impulse source, fastest legal spacing
module impulse_source (
  input  wire logic       clk_sys_i,
  input  wire logic [4:0] count_i,
  input  wire logic       go_i,
  output logic            impulse_o,
  output logic            busy_o
);
  logic [5:0] left_reg = 6'h00;
  // two half-slots per impulse: one cycle high, one cycle low
  always @(negedge clk_sys_i) begin
    if (go_i && left_reg == 6'h00) left_reg <= {count_i, 1'b0};
    else if (left_reg != 6'h00) left_reg <= left_reg - 6'h01;
  end
  // odd slots high, so the line rests low between bursts
  assign impulse_o = left_reg[0];
  assign busy_o    = left_reg != 6'h00;
endmodule // impulse_source
`default_nettype wire

/* File: ripple_props.sv */
`timescale 1ns/10ps
`default_nettype none
module ripple_props (
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic       cancel_i,
  input wire logic       impulse_i,
  input wire logic [3:0] digit_o,
  input wire logic       wrap_o,
  input wire logic [3:0] on_pulse_o,
  input wire logic       on_level_line_o,
  input wire logic       off_level_line_o,
  input wire logic       on_state_driver_o,
  input wire logic       off_state_driver_o,
  input wire logic       gate_pulse_o,
  input wire logic       edge_stage_o,
  input wire logic       qual_stage_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // lines follow stage one, drivers mirror the lines
  level_pair_a:
    assert property (on_level_line_o == digit_o[0] && off_level_line_o
      == !digit_o[0] && on_state_driver_o == on_level_line_o
      && off_state_driver_o == off_level_line_o) else $error("bad levels");
  // pulses leave with the stage flop, one cycle ahead of the digit view
  rise_pulse_a:
    assert property ($past(on_pulse_o) == (digit_o & ~$past(digit_o)))
      else $error("bad on pulse");
  count_step_a:
    assert property ($changed(digit_o) |-> digit_o == $past(digit_o)
      + 4'h1 || digit_o == 4'h0) else $error("bad count step");
  wrap_zero_a:
    assert property (wrap_o |=> digit_o == 4'h0 && $past(digit_o) == 4'hf)
      else $error("bad wrap");
  // six quiet cycles outlast the input latency
  hold_still_a:
    assert property ((!impulse_i && !cancel_i) [*6] |=> $stable(digit_o))
      else $error("count drifted");
  gate_cause_a:
    assert property (gate_pulse_o |-> qual_stage_o ##1 $rose(edge_stage_o))
      else $error("gate without cause");
  gate_fire_a:
    assert property ($rose(edge_stage_o) && $past(qual_stage_o) |->
      $past(gate_pulse_o)) else $error("gate missing");
  gate_once_a:
    assert property (gate_pulse_o |=> !gate_pulse_o)
      else $error("gate too long");
  standby_hold_a:
    assert property (cancel_i [*6] |-> digit_o == 4'h0 && !edge_stage_o
      && qual_stage_o) else $error("bad stand-by");
  // main scenarios reached
  cover property (wrap_o);
  cover property (gate_pulse_o);
  cover property (on_pulse_o[3]);
endmodule // ripple_props
bind binary_ripple_counter ripple_props ripple_props_i (.*);
`default_nettype wire

/* File: binary_ripple_counter_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module binary_ripple_counter_tb;
  logic       clk_sys_i = 1'b0;
  logic       rst_n_i   = 1'b0;
  logic       cancel_i  = 1'b0;
  logic [3:0] ctl       = 4'h0;
  logic [4:0] count     = 5'h00;
  logic       go        = 1'b0;
  logic [3:0] wraps     = 4'h0;
  logic [3:0] gates     = 4'h0;
  logic [3:0] digit_o, on_pulse_o;
  logic       wrap_o, on_level_line_o, off_level_line_o, gate_pulse_o;
  logic       on_state_driver_o, off_state_driver_o;
  logic       edge_stage_o, qual_stage_o;
  wire        impulse_i, busy, edge_set_i, edge_clear_i;
  wire        qual_set_i, qual_clear_i;
  int         errors, checks_done;
  // rows: impulses to add, running digit expected
  logic [7:0] rows [6] = '{8'h11, 8'h12, 8'h24, 8'h48, 8'h7f, 8'h10};
  assign {qual_clear_i, qual_set_i, edge_clear_i, edge_set_i} = ctl;
  binary_ripple_counter binary_ripple_counter_i (.*);
  impulse_source impulse_source_i (.clk_sys_i, .count_i(count), .go_i(go),
    .impulse_o(impulse_i), .busy_o(busy));
  always #12.5 clk_sys_i = ~clk_sys_i;
  // pulse outputs stand one cycle, so count them at every edge
  always @(posedge clk_sys_i) begin
    if (wrap_o === 1'b1) wraps <= wraps + 4'h1;
    if (gate_pulse_o === 1'b1) gates <= gates + 4'h1;
  end
  task automatic check(input string what, input logic [3:0] exp,
                       input logic [3:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // burst through the far side, then let the four-edge latency pass
  task automatic pulses(input logic [3:0] n);
    int k;
    @(negedge clk_sys_i);
    count <= {1'b0, n};
    go <= 1'b1;
    @(negedge clk_sys_i);
    go <= 1'b0;
    k = 0;
    do begin
      @(negedge clk_sys_i);
      k++;
    end while (busy && k < 64);
    if (k == 64) begin
      errors++;
      report_and_stop();
    end
    repeat (6) @(negedge clk_sys_i);
  endtask
  task automatic poke(input int k);
    @(negedge clk_sys_i);
    ctl[k] <= 1'b1;
    @(negedge clk_sys_i);
    ctl[k] <= 1'b0;
    repeat (6) @(negedge clk_sys_i);
  endtask
  initial begin
    // an initialiser makes no edge, so look after the first clock edge
    @(negedge clk_sys_i);
    check("reset", 4'h5, {on_level_line_o, off_level_line_o,
      edge_stage_o, qual_stage_o});
    check("reset drv", 4'h1, {wrap_o, gate_pulse_o, on_state_driver_o,
      off_state_driver_o});
    check("reset digit", 4'h0, digit_o);
    @(negedge clk_sys_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      pulses(rows[i][7:4]);
      check("digit", rows[i][3:0], digit_o);
    end
    check("wraps", 4'h1, wraps);
    poke(0);
    check("gate fired", 4'h1, gates);
    // set while on, then edge with qualifier off: both silent
    poke(0);
    poke(1);
    poke(3);
    poke(0);
    poke(2);
    check("gate held", 4'h1, gates);
    check("stages", 4'h3, {2'h0, edge_stage_o, qual_stage_o});
    // cancel in mid-count with qualifier off
    pulses(4'h5);
    check("digit mid", 4'h5, digit_o);
    poke(3);
    cancel_i <= 1'b1;
    repeat (8) @(negedge clk_sys_i);
    check("cancel", 4'h9, {digit_o == 4'h0, 1'b0, edge_stage_o,
      qual_stage_o});
    cancel_i <= 1'b0;
    repeat (4) @(negedge clk_sys_i);
    pulses(4'h1);
    check("after cancel", 4'h1, digit_o);
    report_and_stop();
  end
endmodule // binary_ripple_counter_tb
`default_nettype wire
